// [design/two_wire_unit.sv]
// two-wire unit: address recognition, job-done handshake, byte engine, apb registers
//
// Local design decisions: the register addresses and the APB interface to the registers.
module two_wire_unit #(
  parameter logic [7:0] RATE_DEFAULT = two_wire_pkg::RATE_RESET
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire two_wire_pkg::apb_req_t apb_in,
  output two_wire_pkg::apb_rsp_t      apb_out,
  input  wire logic                   global_irq_en_in,
  input  wire two_wire_pkg::line_t    lines_in,
  output two_wire_pkg::line_t         lines_out,
  output two_wire_pkg::line_t         lines_oe_out,
  output logic                        irq_out
);
  import two_wire_pkg::*;

  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own);
    addr_hit = (rx[7:1] == own[7:1]) || (own[0] && rx[7:1] == GC_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by the second
  line_t s1_q, s2_q, s3_q;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end
    else
    begin
      s1_q <= lines_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire scl_rise   = s2_q.scl & ~s3_q.scl;
  wire scl_fall   = ~s2_q.scl & s3_q.scl;
  wire start_seen = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
  wire stop_seen  = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  state_t     state_q, state_d;
  logic [1:0] ph_q, ph_d, ps_q;
  logic [3:0] bit_q, bit_d;
  logic [7:0] data_q, data_d, sla_q, rate_q, div_q;
  logic [4:0] code_q, ev_code;
  logic       samp_q, samp_d, rd_q, rd_d, addr_ph_q, addr_ph_d;
  logic       master_q, master_d, ack_q, ack_d, ev, sto_done;
  logic       flag_q, ack_en_q, sta_q, sto_q, wc_q, en_q, ie_q, busy_q;
  logic       scl_oe_q, sda_oe_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, registers sampled in the setup cycle
  wire setup    = apb_in.psel & ~apb_in.penable;
  wire wr       = apb_in.psel & apb_in.penable & apb_in.pwrite;
  wire is_ctrl  = apb_in.paddr == OFS_CTRL;
  wire is_stat  = apb_in.paddr == OFS_STAT;
  wire is_data  = apb_in.paddr == OFS_DATA;
  wire is_sla   = apb_in.paddr == OFS_SLA;
  wire is_rate  = apb_in.paddr == OFS_RATE;
  wire mapped   = is_ctrl | is_stat | is_data | is_sla | is_rate;
  wire wr_ctrl  = wr & is_ctrl;
  wire wr_data  = wr & is_data;
  wire clr      = wr_ctrl & apb_in.pwdata[CB_FLAG];
  wire [7:0] ctrl_view = {flag_q, ack_en_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
  // code only meaningful while the flag stands
  wire [4:0] code_view = flag_q ? code_q : C_NONE;
  wire [7:0] stat_view = {code_view, 1'b0, ps_q};
  wire [7:0] rsel = is_ctrl ? ctrl_view : is_stat ? stat_view : is_data ? data_q :
                    is_sla ? sla_q : is_rate ? rate_q : BYTE_ZERO;
  assign apb_out.prdata  = prdata_q;
  assign apb_out.pready  = 1'b1;
  assign apb_out.pslverr = pslverr_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q  <= {RD_PAD, rsel};
      pslverr_q <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter-bit tick; prescaler bits are stored but not applied
  wire tick = div_q == rate_q;
  wire [7:0] rx_byte = {data_q[6:0], samp_q};
  wire nack = samp_q;

  always_comb
  begin
    state_d   = state_q;
    ph_d      = ph_q;
    bit_d     = bit_q;
    data_d    = data_q;
    samp_d    = samp_q;
    rd_d      = rd_q;
    addr_ph_d = addr_ph_q;
    master_d  = master_q;
    ack_d     = ack_q;
    ev        = 1'b0;
    ev_code   = code_q;
    sto_done  = 1'b0;
    if (!en_q)
      state_d = ST_IDLE;
    else
      case (state_q)
        ST_IDLE:
        begin
          sto_done = sto_q;
          if (!flag_q && sta_q)
          begin
            state_d = busy_q ? ST_WAIT_FREE : ST_START;
            ph_d    = PH0;
          end
          else if (start_seen)
          begin
            state_d   = ST_SBIT;
            bit_d     = BIT_ZERO - BIT_ONE; // the fall that ends the start is not a bit
            addr_ph_d = 1'b1;
            ack_d     = 1'b0;
            rd_d      = 1'b0;
            master_d  = 1'b0;
          end
        end
        ST_WAIT_FREE:
        begin
          if (!busy_q)
            state_d = ST_START;
          ph_d = PH0;
        end
        ST_START:
        begin
          if (tick)
            case (ph_q)
              PH0: ph_d = s2_q.scl ? PH1 : PH0;
              PH1: ph_d = PH2;
              default:
              begin
                ev        = 1'b1;
                ev_code   = C_START;
                state_d   = ST_HOLD;
                master_d  = 1'b1;
                addr_ph_d = 1'b1;
              end
            endcase
        end
        ST_MBIT:
        begin
          if (tick)
            case (ph_q)
              PH0: ph_d = PH1;
              PH1: ph_d = s2_q.scl ? PH2 : PH1;
              PH2:
              begin
                samp_d = s2_q.sda;
                ph_d   = PH3;
              end
              default:
              begin
                if (bit_q == LAST_BIT)
                begin
                  ev        = 1'b1;
                  state_d   = ST_HOLD;
                  addr_ph_d = 1'b0;
                  if (addr_ph_q)
                    ev_code = rd_q ? (nack ? C_MR_SLA_NACK : C_MR_SLA_ACK) : (nack ? C_SLA_NACK : C_SLA_ACK);
                  else if (rd_q)
                    ev_code = ack_en_q ? C_MR_DATA_ACK : C_MR_DATA_NACK;
                  else
                    ev_code = nack ? C_DATA_NACK : C_DATA_ACK;
                end
                else
                begin
                  data_d = rx_byte;
                  bit_d  = bit_q + BIT_ONE;
                  ph_d   = PH0;
                end
              end
            endcase
        end
        ST_STOP:
        begin
          if (tick)
            case (ph_q)
              PH0: ph_d = PH1;
              PH1: ph_d = s2_q.scl ? PH2 : PH1;
              default:
              begin
                state_d  = ST_IDLE;
                sto_done = 1'b1;
                master_d = 1'b0;
              end
            endcase
        end
        ST_HOLD:
        begin
          if (clr)
          begin
            ph_d  = PH0;
            bit_d = BIT_ZERO;
            if (master_q && apb_in.pwdata[CB_STA])
              state_d = ST_START;
            else if (apb_in.pwdata[CB_STO])
              state_d = master_q ? ST_STOP : ST_IDLE;
            else if (master_q)
            begin
              state_d = ST_MBIT;
              if (addr_ph_q)
                rd_d = data_q[0];
            end
            else
              state_d = (code_q == C_SR_STOP) ? ST_IDLE : ST_SBIT;
          end
        end
        ST_SBIT:
        begin
          if (stop_seen)
          begin
            state_d = addr_ph_q ? ST_IDLE : ST_HOLD;
            ev      = ~addr_ph_q;
            ev_code = C_SR_STOP;
          end
          else if (start_seen)
          begin
            bit_d     = BIT_ZERO - BIT_ONE;
            addr_ph_d = 1'b1;
            ack_d     = 1'b0;
            rd_d      = 1'b0;
          end
          else if (scl_rise)
            samp_d = s2_q.sda;
          else if (scl_fall)
          begin
            if (bit_q == LAST_BIT)
            begin
              ev        = 1'b1;
              state_d   = ST_HOLD;
              bit_d     = BIT_ZERO;
              addr_ph_d = 1'b0;
              if (addr_ph_q)
                ev_code = (data_q[7:1] == GC_ADDR) ? C_SR_GC : (rd_q ? C_ST_ADDR : C_SR_ADDR);
              else
                ev_code = rd_q ? (nack ? C_ST_DATA_NACK : C_ST_DATA_ACK) : C_SR_DATA;
            end
            else
            begin
              data_d = rx_byte;
              bit_d  = bit_q + BIT_ONE;
              if (bit_q == LAST_DATA)
              begin
                // unaddressed or ack disabled: drop off the bus quietly
                if (addr_ph_q && !(ack_en_q && addr_hit(rx_byte, sla_q)))
                  state_d = ST_IDLE;
                rd_d  = addr_ph_q ? rx_byte[0] : rd_q;
                ack_d = addr_ph_q | ack_en_q;
              end
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    if (wr_data && flag_q)
      data_d = apb_in.pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, open drain: only ever pulls low
  wire m_sda = (bit_q < LAST_BIT) ? ((addr_ph_q | ~rd_q) & ~data_q[7]) : (rd_q & ~addr_ph_q & ack_en_q);
  wire s_sda = (bit_q < LAST_BIT) ? (rd_q & ~addr_ph_q & ~data_q[7]) : (ack_q & (addr_ph_q | ~rd_q));
  wire scl_low_d = en_q & (flag_q |
                   (state_q == ST_MBIT & (ph_q == PH0 | ph_q == PH3)) |
                   (state_q == ST_START & ph_q == PH2) | (state_q == ST_STOP & ph_q == PH0));
  wire sda_low_d = en_q & ((state_q == ST_MBIT & m_sda) | (state_q == ST_SBIT & s_sda) |
                   (state_q == ST_START & ph_q != PH0) | (state_q == ST_STOP & ph_q != PH2));
  assign lines_out        = '0;
  assign lines_oe_out.scl = scl_oe_q;
  assign lines_oe_out.sda = sda_oe_q;
  assign irq_out = flag_q & ie_q & global_irq_en_in;

  ////////////////////////////////////////////////////////////////////////////
  // engine registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q   <= ST_IDLE;
      ph_q      <= PH0;
      bit_q     <= BIT_ZERO;
      data_q    <= BYTE_ZERO;
      samp_q    <= 1'b1;
      rd_q      <= 1'b0;
      addr_ph_q <= 1'b0;
      master_q  <= 1'b0;
      ack_q     <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      ph_q      <= ph_d;
      bit_q     <= bit_d;
      data_q    <= data_d;
      samp_q    <= samp_d;
      rd_q      <= rd_d;
      addr_ph_q <= addr_ph_d;
      master_q  <= master_d;
      ack_q     <= ack_d;
    end
  end

  // software registers; a hardware set of the flag beats a software clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flag_q   <= 1'b0;
      code_q   <= C_NONE;
      ack_en_q <= 1'b0;
      sta_q    <= 1'b0;
      sto_q    <= 1'b0;
      wc_q     <= 1'b0;
      en_q     <= 1'b0;
      ie_q     <= 1'b0;
      sla_q    <= SLA_RESET;
      rate_q   <= RATE_DEFAULT;
      ps_q     <= PS_RESET;
    end
    else
    begin
      flag_q <= ev | (flag_q & ~clr);
      if (ev)
        code_q <= ev_code;
      if (wr_ctrl)
      begin
        ack_en_q <= apb_in.pwdata[CB_ACK];
        sta_q    <= apb_in.pwdata[CB_STA];
        en_q     <= apb_in.pwdata[CB_EN];
        ie_q     <= apb_in.pwdata[CB_IE];
      end
      if (wr_ctrl)
        sto_q <= apb_in.pwdata[CB_STO];
      else if (sto_done)
        sto_q <= 1'b0;
      if (wr_data)
        wc_q <= ~flag_q;
      if (wr & is_sla)
        sla_q <= apb_in.pwdata[7:0];
      if (wr & is_rate)
        rate_q <= apb_in.pwdata[7:0];
      if (wr & is_stat)
        ps_q <= apb_in.pwdata[1:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_q    <= BYTE_ZERO;
      busy_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      div_q    <= tick ? BYTE_ZERO : div_q + 8'h01;
      busy_q   <= start_seen | (busy_q & ~stop_seen);
      scl_oe_q <= scl_low_d;
      sda_oe_q <= sda_low_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_FLAG_SET: assert property (ev |=> flag_q && code_view == $past(ev_code))
    else $error("event did not set flag and code");
  AST_CLEAR: assert property (clr && !ev |=> !flag_q)
    else $error("flag not cleared by write");
  AST_SCL_HOLD: assert property (flag_q && en_q |=> scl_oe_q)
    else $error("scl released while flag set");
  AST_NO_START: assert property (flag_q && state_q == ST_IDLE |=> state_q != ST_START)
    else $error("operation began while flag set");
  AST_NOINFO: assert property (setup && is_stat && !flag_q |=> apb_out.prdata[CODE_MSB:CODE_LSB] == C_NONE)
    else $error("status showed a code without flag");
  AST_START_CODE: assert property (ev && state_q == ST_START |=> flag_q && code_q == C_START)
    else $error("start sent without start code");
  AST_STOP_QUIET: assert property (state_q == ST_STOP && !flag_q |=> !flag_q)
    else $error("flag set by stop");
  AST_GC: assert property (ev && ev_code == C_SR_GC |-> sla_q[0])
    else $error("general call taken while disabled");
  AST_MATCH: assert property (ev && ev_code == C_SR_ADDR |-> data_q[7:1] == sla_q[7:1])
    else $error("own address event without match");
  AST_WAIT: assert property (state_q == ST_WAIT_FREE && busy_q |=> state_q != ST_START)
    else $error("start while bus busy");
  AST_IRQ: assert property (flag_q && ie_q && global_irq_en_in |-> irq_out)
    else $error("irq missing");
endmodule

// [design/two_wire_pkg.sv]
// constants and types for the two-wire unit
// How it works
// - upper seven address bits hold own address
// - address bit zero enables general call
// - comparator match raises job-done event
// - address register resets to 0xFE, fully RW
// - every bus event except STOP sent sets job-done flag
// - irq needs flag, local and global enable
// - status code valid while flag set
// - writing one to flag bit clears it
// - no operation starts while flag set
// - sent START sets flag with start code
// - address packet sent reports ack result
// - data byte sent reports ack result
// - STOP sent, flag stays clear
// - scl held low while flag set and unit enabled
// - status code in bits seven to three
// - flag clear shows no-information code
// - busy bus: wait for STOP, then START
package two_wire_pkg;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STAT   = 8'h04;
  localparam logic [7:0]  OFS_DATA   = 8'h08;
  localparam logic [7:0]  OFS_SLA    = 8'h0C;
  localparam logic [7:0]  OFS_RATE   = 8'h10;
  localparam logic [7:0]  SLA_RESET  = 8'hFE;
  localparam logic [7:0]  RATE_RESET = 8'h10;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [1:0]  PS_RESET   = 2'h0;
  localparam logic [23:0] RD_PAD     = 24'h00_0000;
  localparam int CB_FLAG  = 7;
  localparam int CB_ACK   = 6;
  localparam int CB_STA   = 5;
  localparam int CB_STO   = 4;
  localparam int CB_EN    = 2;
  localparam int CB_IE    = 0;
  localparam int CODE_LSB = 3;
  localparam int CODE_MSB = 7;
  localparam logic [3:0] BIT_ZERO  = 4'h0;
  localparam logic [3:0] BIT_ONE   = 4'h1;
  localparam logic [3:0] LAST_DATA = 4'h7;
  localparam logic [3:0] LAST_BIT  = 4'h8;
  localparam logic [6:0] GC_ADDR   = 7'h00;
  localparam logic [1:0] PH0 = 2'h0;
  localparam logic [1:0] PH1 = 2'h1;
  localparam logic [1:0] PH2 = 2'h2;
  localparam logic [1:0] PH3 = 2'h3;
  localparam logic [4:0] C_START        = 5'h01;
  localparam logic [4:0] C_SLA_ACK      = 5'h03;
  localparam logic [4:0] C_SLA_NACK     = 5'h04;
  localparam logic [4:0] C_DATA_ACK     = 5'h05;
  localparam logic [4:0] C_DATA_NACK    = 5'h06;
  localparam logic [4:0] C_MR_SLA_ACK   = 5'h08;
  localparam logic [4:0] C_MR_SLA_NACK  = 5'h09;
  localparam logic [4:0] C_MR_DATA_ACK  = 5'h0A;
  localparam logic [4:0] C_MR_DATA_NACK = 5'h0B;
  localparam logic [4:0] C_SR_ADDR      = 5'h0C;
  localparam logic [4:0] C_SR_GC        = 5'h0E;
  localparam logic [4:0] C_SR_DATA      = 5'h10;
  localparam logic [4:0] C_SR_STOP      = 5'h14;
  localparam logic [4:0] C_ST_ADDR      = 5'h15;
  localparam logic [4:0] C_ST_DATA_ACK  = 5'h17;
  localparam logic [4:0] C_ST_DATA_NACK = 5'h18;
  localparam logic [4:0] C_NONE         = 5'h1F;
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_FREE, ST_START, ST_MBIT, ST_STOP, ST_HOLD, ST_SBIT} state_t;
endpackage

// [tb/two_wire_peer.sv]
// behavioural bus peer: a master on demand, otherwise a slave that acks only while ack_on_in is high
module two_wire_peer (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       ack_on_in,
  output logic            scl_low_out,
  output logic            sda_low_out,
  output logic [7:0]      rx_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       m_scl = 1'b0;
  logic       m_sda = 1'b0;
  logic       s_sda = 1'b0;
  logic       act   = 1'b0;
  logic [3:0] cnt   = 4'h0;
  initial rx_out = 8'h00;
  // open drain: a released line floats to the pull-up, never to the last value
  assign scl_low_out = m_scl;
  assign sda_low_out = m_sda | s_sda;
  ////////////////////////////////////////////////////////////
  always @(negedge sda_in)
    if (scl_in)
    begin
      act = 1'b1;
      cnt = 4'h0;
    end
  always @(posedge sda_in)
    if (scl_in)
    begin
      act   = 1'b0;
      s_sda = 1'b0;
    end
  // counted on rises so the fall that ends a start is not taken for a bit
  always @(posedge scl_in)
    if (act)
    begin
      if (cnt < 4'h8)
        rx_out = {rx_out[6:0], sda_in};
      cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  always @(negedge scl_in)
    s_sda = act && ack_on_in && cnt == 4'h8;
  ////////////////////////////////////////////////////////////
  task automatic start_c();
    m_sda = 1'b1;
    #16;
    m_scl = 1'b1;
    #16;
  endtask
  task automatic bit_c(input logic b, output logic r);
    m_sda = !b;
    #16;
    m_scl = 1'b0;
    // a stretching unit keeps us here
    wait (scl_in);
    #32;
    r = sda_in;
    m_scl = 1'b1;
    #16;
  endtask
  task automatic stop_c();
    m_sda = 1'b1;
    #16;
    m_scl = 1'b0;
    wait (scl_in);
    #16;
    m_sda = 1'b0;
    #32;
  endtask
  task automatic send(input logic [7:0] v, output logic nak);
    logic r;
    start_c();
    for (int i = 7; i >= 0; i--)
      bit_c(v[i], r);
    bit_c(1'b1, nak);
  endtask
endmodule

// [tb/tb_two_wire_address_and_handshake.sv]
// testbench: apb software driving the two-wire unit against a bus peer
module tb_two_wire_address_and_handshake;
  timeunit 1ns;
  timeprecision 100ps;
  import two_wire_pkg::*;
  typedef struct packed {
    logic [7:0] sla;
    logic [7:0] adr;
    logic       nak;
    logic [7:0] code;
  } row_t;
  logic       clk_in     = 1'b0;
  logic       rst_in     = 1'b1;
  logic       glb        = 1'b0;
  logic       ack_on     = 1'b0;
  logic       irq_out;
  logic       perr;
  logic       p_scl;
  logic       p_sda;
  logic [7:0] rx;
  apb_req_t   req        = '0;
  apb_rsp_t   rsp;
  line_t      oe;
  line_t      lv;
  line_t      lo;
  int         errors     = 0;
  int         num_checks = 0;
  row_t       rows [6]   = '{
    '{8'h54, 8'h54, 1'b0, 8'h60},
    '{8'h54, 8'h55, 1'b0, 8'hA8},
    '{8'h54, 8'h00, 1'b1, 8'hF8},
    '{8'h55, 8'h00, 1'b0, 8'h70},
    '{8'h55, 8'h56, 1'b1, 8'hF8},
    '{8'h55, 8'h54, 1'b0, 8'h60}
  };
  assign lv = {~oe.scl & ~p_scl, ~oe.sda & ~p_sda};
  // small rate keeps each byte short; the peer still sees every edge
  two_wire_unit #(.RATE_DEFAULT(8'h03)) i_two_wire_unit (
    .clk_in(clk_in), .rst_in(rst_in), .apb_in(req), .apb_out(rsp),
    .global_irq_en_in(glb), .lines_in(lv), .lines_out(lo), .lines_oe_out(oe),
    .irq_out(irq_out));
  two_wire_peer i_two_wire_peer (
    .scl_in(lv.scl), .sda_in(lv.sda), .ack_on_in(ack_on),
    .scl_low_out(p_scl), .sda_low_out(p_sda), .rx_out(rx));
  initial
  begin
    forever #4 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= {24'h00_0000, d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    // pready is tied high, so this wait ends after one clock
    do
    begin
      @(posedge clk_in);
    end
    while (rsp.pready !== 1'b1);
    q    = rsp.prdata[7:0];
    perr = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic wait_flag(input logic [7:0] code, input logic irq);
    logic [7:0] q;
    q = 8'h00;
    while (q[7] !== 1'b1)
    begin
      apb(1'b0, OFS_CTRL, 8'h00, q);
    end
    chk("flag", 8'h80, q & 8'h80);
    chk("scl_held", 8'h01, {7'h00, oe.scl});
    chk("irq", {7'h00, irq}, {7'h00, irq_out});
    rd(OFS_STAT, code, "status");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] q;
    logic       nak;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(OFS_SLA, 8'hFE, "sla_reset");
    rd(OFS_STAT, 8'hF8, "stat_idle");
    rd(OFS_CTRL, 8'h00, "ctrl_reset");
    rd(8'h14, 8'h00, "unmapped");
    chk("slverr", 8'h01, {7'h00, perr});
    apb(1'b1, OFS_SLA, 8'hA5, q);
    rd(OFS_SLA, 8'hA5, "sla_rw");
    apb(1'b1, OFS_STAT, 8'h03, q);
    rd(OFS_STAT, 8'hFB, "stat_ps");
    apb(1'b1, OFS_STAT, 8'h00, q);
    apb(1'b1, OFS_DATA, 8'h11, q);
    rd(OFS_CTRL, 8'h08, "collision");
    $display("test registers done");
    glb <= 1'b1;
    apb(1'b1, OFS_CTRL, 8'h45, q);
    foreach (rows[i])
    begin
      apb(1'b1, OFS_SLA, rows[i].sla, q);
      i_two_wire_peer.send(rows[i].adr, nak);
      chk("addr_ack", {7'h00, rows[i].nak}, {7'h00, nak});
      if (rows[i].code != 8'hF8)
        wait_flag(rows[i].code, 1'b1);
      else
        rd(OFS_STAT, 8'hF8, "no_match");
      apb(1'b1, OFS_CTRL, 8'h80, q);
      i_two_wire_peer.stop_c();
      apb(1'b1, OFS_CTRL, 8'h45, q);
      $display("test row %0d done", i);
    end
    // unit off while the peer claims the bus, so the start has to wait
    apb(1'b1, OFS_CTRL, 8'h00, q);
    ack_on <= 1'b1;
    i_two_wire_peer.start_c();
    apb(1'b1, OFS_CTRL, 8'hA4, q);
    repeat (60) @(posedge clk_in);
    apb(1'b0, OFS_CTRL, 8'h00, q);
    chk("busy_wait", 8'h00, {7'h00, q[7]});
    i_two_wire_peer.stop_c();
    wait_flag(8'h08, 1'b0);
    apb(1'b1, OFS_CTRL, 8'h25, q);
    repeat (40) @(posedge clk_in);
    rd(OFS_STAT, 8'h08, "held");
    apb(1'b1, OFS_DATA, 8'hA6, q);
    apb(1'b1, OFS_CTRL, 8'h85, q);
    wait_flag(8'h18, 1'b1);
    chk("rx_addr", 8'hA6, rx);
    glb <= 1'b0;
    @(posedge clk_in);
    chk("irq_gate", 8'h00, {7'h00, irq_out});
    glb <= 1'b1;
    apb(1'b1, OFS_DATA, 8'h3C, q);
    apb(1'b1, OFS_CTRL, 8'h84, q);
    wait_flag(8'h28, 1'b0);
    chk("rx_data", 8'h3C, rx);
    ack_on <= 1'b0;
    apb(1'b1, OFS_DATA, 8'h5A, q);
    apb(1'b1, OFS_CTRL, 8'h84, q);
    wait_flag(8'h30, 1'b0);
    apb(1'b1, OFS_CTRL, 8'h94, q);
    repeat (300) @(posedge clk_in);
    apb(1'b0, OFS_CTRL, 8'h00, q);
    chk("stop_done", 8'h00, q & 8'h90);
    rd(OFS_STAT, 8'hF8, "after_stop");
    chk("lines_out", 8'h00, {6'h00, lo});
    $display("test master done");
    wrap_up();
  end
  // the whole run needs well under this span
  initial
  begin
    #400_000;
    errors++;
    wrap_up();
  end
endmodule
